// ==== design/adrt_pkg.sv ====
package adrt_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;   // enable, resolution, simultaneous, start
  localparam logic [ADDR_W-1:0] REG_TIMING = 4'h2; // conversion_timing_control
  localparam logic [ADDR_W-1:0] REG_CHSEL = 4'h4;  // input channel number
  localparam logic [ADDR_W-1:0] REG_PINSHR = 4'h6; // per-pin shared function enables
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8; // busy, done, refused
  localparam logic [ADDR_W-1:0] REG_RESULT = 4'hA; // last conversion result
  // control register fields
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_RES_BIT = 10;
  localparam int CTRL_SIM_BIT = 3;
  localparam int CTRL_START_BIT = 0;
  // conversion_timing_control fields
  localparam int TIM_SRC_BIT = 15;
  localparam int TIM_AUTO_SAMPLE_TIME_LSB = 8;
  localparam int TIM_AUTO_SAMPLE_TIME_W = 5;
  localparam int TIM_DIV_LSB = 0;
  localparam int TIM_DIV_W = 8;
  localparam logic [DATA_W-1:0] TIMING_RST = 16'h0000;
  localparam logic [DATA_W-1:0] TIMING_MASK = 16'h9FFF; // bits 14:13 read zero
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_REFUSED_BIT = 2;
  // conversion geometry
  localparam int MAX_CH = 16;
  localparam int CH_W = 4;
  localparam int RES_W = 12;
  localparam int SH_W = 4;
  localparam logic [3:0] NBITS_10 = 4'hA;
  localparam logic [3:0] NBITS_12 = 4'hC;
  localparam logic [SH_W-1:0] SH_ONE = 4'h1;
  localparam logic [SH_W-1:0] SH_ALL = 4'hF;
  // throughput limits, rates in ksps, clock in kHz
  localparam int CLK_KHZ = 250000;
  localparam int RATE_12B_KSPS = 500;
  localparam int RATE_10B_KSPS = 1100;
  localparam int MIN_CYC_12B = (CLK_KHZ + RATE_12B_KSPS - 1) / RATE_12B_KSPS;
  localparam int MIN_CYC_10B = (CLK_KHZ + RATE_10B_KSPS - 1) / RATE_10B_KSPS;
  localparam int RATE_W = 10;
  // sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SAMPLE = 4'h2,
    ST_CONVERT = 4'h4,
    ST_HOLDOFF = 4'h8
  } adrt_state_t;
endpackage

// ==== design/adrt_tad_if.sv ====
`timescale 1ns/100ps
interface adrt_tad_if;
  logic run;       // divider runs while high
  logic src;       // 1: rc ticks, 0: every clock
  logic rc_tick;   // rc oscillator event
  logic [7:0] div; // period minus one
  logic tad_tick;  // one conversion clock period elapsed
  modport ctl (output run, output src, output rc_tick, output div, input tad_tick);
  modport gen (input run, input src, input rc_tick, input div, output tad_tick);
endinterface

// ==== design/adrt_tad_gen.sv ====
`timescale 1ns/100ps
module adrt_tad_gen
  import adrt_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  adrt_tad_if.gen tad
);
  logic [TIM_DIV_W-1:0] cnt_r; // source periods seen in this tad
  logic [TIM_DIV_W-1:0] cnt_nxt;
  logic step; // one source period

  // source select and terminal count
  always_comb begin
    step = tad.src ? tad.rc_tick : 1'b1;
    cnt_nxt = cnt_r;
    if (!tad.run) begin
      cnt_nxt = '0;
    end else if (step) begin
      cnt_nxt = (cnt_r == tad.div) ? '0 : cnt_r + 1'b1;
    end
  end

  assign tad.tad_tick = tad.run && step && (cnt_r == tad.div);

  // counter register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // helper: clocks since last tick with steady settings
  logic [8:0] gap_r;
  logic seen_r;
  always_ff @(posedge clk) begin
    if (sys_rst || !tad.run || tad.src || tad.div != $past(tad.div)) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else if (tad.tad_tick) begin
      gap_r <= '0;
      seen_r <= 1'b1;
    end else begin
      gap_r <= gap_r + 1'b1;
    end
  end

  a_tad_gap_len: assert property (@(posedge clk) disable iff (sys_rst)
    (tad.tad_tick && seen_r && !tad.src && $stable(tad.div)) |-> gap_r == {1'b0, tad.div})
    else $error("tad period differs from divider plus one");
endmodule // adrt_tad_gen

// ==== design/adrt_ctrl.sv ====
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// Contract
// - 12-bit keeps all 10-bit features except limits
// - 12-bit throughput at most 500 ksps; disabling ends the holdoff, so a re-enabled start can come sooner
// - 12-bit uses one sample-and-hold only
// - channel number selects one of sixteen inputs
// - shared pin in use makes channel unavailable
// - control bit 10 selects 10 or 12 bits
// - 10-bit throughput at most 1.1 Msps; disabling ends the holdoff, so a re-enabled start can come sooner
module adrt_ctrl
  import adrt_pkg::*;
#(
  parameter logic [MAX_CH-1:0] CH_PRESENT = 16'hFFFF // inputs bonded out on this variant
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic rc_tick,
  input wire logic sar_comp,
  output logic [SH_W-1:0] sh_active,
  output logic [CH_W-1:0] chan_sel,
  output logic sampling,
  output logic converting,
  output logic [RES_W-1:0] sar_trial,
  output logic conv_done
);
  // register state
  logic on_r, on_nxt;                       // converter enabled
  logic res_r, res_nxt;                     // resolution_select, 1 = 12 bit
  logic sim_r, sim_nxt;                     // simultaneous sampling request
  logic [DATA_W-1:0] timing_r, timing_nxt;  // conversion_timing_control
  logic [CH_W-1:0] chsel_r, chsel_nxt;      // requested channel
  logic [MAX_CH-1:0] pinshr_r, pinshr_nxt;  // op amp, comparator or vref on pin
  logic done_r, done_nxt;                   // sticky conversion done
  logic refused_r, refused_nxt;             // sticky start refused
  logic [DATA_W-1:0] rdata_r, rdata_nxt;    // read data, one cycle late
  // sequencer state
  adrt_state_t st_r, st_nxt;
  logic [TIM_AUTO_SAMPLE_TIME_W-1:0] samp_r, samp_nxt;  // tads spent sampling
  logic [3:0] bit_r, bit_nxt;               // bit under trial
  logic [RES_W-1:0] sar_r, sar_nxt;         // successive approximation word
  logic [RES_W-1:0] result_r, result_nxt;   // last result
  logic [RATE_W-1:0] rate_r, rate_nxt;      // clocks since start
  logic [CH_W-1:0] chan_r, chan_nxt;        // channel being converted
  logic [SH_W-1:0] shm_r, shm_nxt;          // sample-and-holds in use
  logic conv_done_r, conv_done_nxt;         // result ready pulse
  // decode and helpers
  logic wr_ctrl, wr_stat, start_req, avail, accept, refuse, tad;
  logic [3:0] nbits;
  logic [TIM_AUTO_SAMPLE_TIME_W-1:0] auto_sample_time;
  logic [RATE_W-1:0] rate_min;
  logic [RES_W-1:0] sar_init, sar_res;

  // tad divider
  adrt_tad_if tad_bus ();
  // divider idles in the last sample cycle so the first conversion tad is a full period
  assign tad_bus.run = on_r && ((st_r == ST_SAMPLE && samp_r != auto_sample_time) || st_r == ST_CONVERT);
  assign tad_bus.src = timing_r[TIM_SRC_BIT];
  assign tad_bus.rc_tick = rc_tick;
  assign tad_bus.div = timing_r[TIM_DIV_LSB +: TIM_DIV_W];
  assign tad = tad_bus.tad_tick;

  adrt_tad_gen u_tad (
    .clk(clk),
    .sys_rst(sys_rst),
    .tad(tad_bus.gen)
  );

  // write decode and start qualification
  always_comb begin
    wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
    wr_stat = reg_wr && (reg_addr == REG_STATUS);
    start_req = wr_ctrl && reg_wdata[CTRL_START_BIT] && reg_wdata[CTRL_ON_BIT];
    avail = CH_PRESENT[chsel_r] && !pinshr_r[chsel_r];
    accept = (st_r == ST_IDLE) && start_req && avail;
    refuse = (st_r == ST_IDLE) && start_req && !avail;
    nbits = res_r ? NBITS_12 : NBITS_10;
    auto_sample_time = timing_r[TIM_AUTO_SAMPLE_TIME_LSB +: TIM_AUTO_SAMPLE_TIME_W];
    // least clocks per conversion for the rate limit
    rate_min = res_r ? RATE_W'(MIN_CYC_12B - 1) : RATE_W'(MIN_CYC_10B - 1);
  end

  // register next values
  always_comb begin
    on_nxt = on_r;
    res_nxt = res_r;
    sim_nxt = sim_r;
    timing_nxt = timing_r;
    chsel_nxt = chsel_r;
    pinshr_nxt = pinshr_r;
    if (wr_ctrl) begin
      on_nxt = reg_wdata[CTRL_ON_BIT];
      sim_nxt = reg_wdata[CTRL_SIM_BIT];
      // resolution only moves while the converter is off
      if (!on_r) begin
        res_nxt = reg_wdata[CTRL_RES_BIT];
      end
    end
    if (reg_wr && reg_addr == REG_TIMING) begin
      timing_nxt = reg_wdata & TIMING_MASK;
    end
    if (reg_wr && reg_addr == REG_CHSEL) begin
      chsel_nxt = reg_wdata[CH_W-1:0];
    end
    if (reg_wr && reg_addr == REG_PINSHR) begin
      pinshr_nxt = reg_wdata[MAX_CH-1:0];
    end
    // sticky flags, a set in the clearing cycle wins
    done_nxt = conv_done_nxt || (done_r && !(wr_stat && reg_wdata[STAT_DONE_BIT]));
    refused_nxt = refuse || (refused_r && !(wr_stat && reg_wdata[STAT_REFUSED_BIT]));
    // read mux, zero outside the answer cycle and on unmapped offsets
    rdata_nxt = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: begin
          rdata_nxt[CTRL_ON_BIT] = on_r;
          rdata_nxt[CTRL_RES_BIT] = res_r;
          rdata_nxt[CTRL_SIM_BIT] = sim_r;
        end
        REG_TIMING: rdata_nxt = timing_r;
        REG_CHSEL: rdata_nxt[CH_W-1:0] = chsel_r;
        REG_PINSHR: rdata_nxt[MAX_CH-1:0] = pinshr_r;
        REG_STATUS: begin
          rdata_nxt[STAT_BUSY_BIT] = (st_r != ST_IDLE);
          rdata_nxt[STAT_DONE_BIT] = done_r;
          rdata_nxt[STAT_REFUSED_BIT] = refused_r;
        end
        REG_RESULT: rdata_nxt[RES_W-1:0] = result_r;
        default: rdata_nxt = '0;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      on_r <= 1'b0;
      res_r <= 1'b0;
      sim_r <= 1'b0;
      timing_r <= TIMING_RST;
      chsel_r <= '0;
      pinshr_r <= '0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      on_r <= on_nxt;
      res_r <= res_nxt;
      sim_r <= sim_nxt;
      timing_r <= timing_nxt;
      chsel_r <= chsel_nxt;
      pinshr_r <= pinshr_nxt;
      done_r <= done_nxt;
      refused_r <= refused_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // successive approximation step values
  always_comb begin
    sar_init = '0;
    sar_init[nbits - 4'h1] = 1'b1; // top bit of the active width
    sar_res = sar_r;
    if (!sar_comp) begin
      sar_res[bit_r] = 1'b0; // input below trial, drop the bit
    end
    if (bit_r != 4'h0) begin
      sar_res[bit_r - 4'h1] = 1'b1;
    end
  end

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    samp_nxt = samp_r;
    bit_nxt = bit_r;
    sar_nxt = sar_r;
    result_nxt = result_r;
    chan_nxt = chan_r;
    shm_nxt = shm_r;
    conv_done_nxt = 1'b0;
    rate_nxt = (st_r == ST_IDLE || rate_r == '1) ? rate_r : rate_r + 1'b1;
    unique case (st_r)
      ST_IDLE: begin
        if (accept) begin
          st_nxt = ST_SAMPLE;
          samp_nxt = '0;
          rate_nxt = '0;
          bit_nxt = nbits - 4'h1;
          sar_nxt = sar_init;
          chan_nxt = chsel_r;
          // one sample-and-hold in 12 bit, simultaneous ignored
          shm_nxt = (sim_r && !res_r) ? SH_ALL : SH_ONE;
        end
      end
      ST_SAMPLE: begin
        if (samp_r == auto_sample_time) begin
          st_nxt = ST_CONVERT;
        end else if (tad) begin
          samp_nxt = samp_r + 1'b1;
        end
      end
      ST_CONVERT: begin
        if (tad) begin
          sar_nxt = sar_res;
          bit_nxt = bit_r - 4'h1;
          if (bit_r == 4'h0) begin
            st_nxt = ST_HOLDOFF;
            result_nxt = sar_res;
            conv_done_nxt = 1'b1;
          end
        end
      end
      ST_HOLDOFF: begin
        // hold the next start until the rate period has run out
        if (rate_r >= rate_min) begin
          st_nxt = ST_IDLE;
        end
      end
    endcase
    // disabling aborts a conversion in flight
    if (!on_r && st_r != ST_IDLE) begin
      st_nxt = ST_IDLE;
      conv_done_nxt = 1'b0; // a cut conversion leaves no result
      result_nxt = result_r;
    end
  end

  // sequencer flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      samp_r <= '0;
      bit_r <= '0;
      sar_r <= '0;
      result_r <= '0;
      rate_r <= '0;
      chan_r <= '0;
      shm_r <= SH_ONE;
      conv_done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      samp_r <= samp_nxt;
      bit_r <= bit_nxt;
      sar_r <= sar_nxt;
      result_r <= result_nxt;
      rate_r <= rate_nxt;
      chan_r <= chan_nxt;
      shm_r <= shm_nxt;
      conv_done_r <= conv_done_nxt;
    end
  end

  // outputs, all from flops
  assign reg_rdata = rdata_r;
  assign sampling = (st_r == ST_SAMPLE);
  assign converting = (st_r == ST_CONVERT);
  assign sh_active = sampling ? shm_r : '0;
  assign chan_sel = chan_r;
  assign sar_trial = sar_r;
  assign conv_done = conv_done_r;

  // helper: spacing between accepted starts, tads per conversion
  localparam int MIN12_M1 = MIN_CYC_12B - 1;
  localparam int MIN10_M1 = MIN_CYC_10B - 1;
  logic [RATE_W-1:0] since_r;
  logic seen_r;
  logic [3:0] ctads_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      since_r <= '0;
      seen_r <= 1'b0;
      ctads_r <= '0;
    end else begin
      since_r <= accept ? '0 : ((since_r == '1) ? since_r : since_r + 1'b1);
      seen_r <= accept || (seen_r && on_r); // spacing only counts within one enabled run
      ctads_r <= accept ? 4'h0 : ((converting && tad) ? ctads_r + 4'h1 : ctads_r);
    end
  end

  a_rate_12b_gap: assert property (@(posedge clk) disable iff (sys_rst)
    (accept && seen_r && res_r) |-> since_r >= MIN12_M1)
    else $error("12-bit start came before the 500 ksps period");

  a_rate_10b_gap: assert property (@(posedge clk) disable iff (sys_rst)
    (accept && seen_r && !res_r) |-> since_r >= MIN10_M1)
    else $error("10-bit start came before the 1.1 Msps period");

  a_single_sh_12b: assert property (@(posedge clk) disable iff (sys_rst)
    (sampling && res_r) |-> sh_active == SH_ONE)
    else $error("more than one sample-and-hold active in 12-bit mode");

  a_chan_in_range: assert property (@(posedge clk) disable iff (sys_rst)
    accept |=> (chan_sel == $past(chsel_r)) && CH_PRESENT[chan_sel] && sampling)
    else $error("conversion started on an absent channel");

  a_shared_pin_refused: assert property (@(posedge clk) disable iff (sys_rst)
    ((st_r == ST_IDLE) && start_req && pinshr_r[chsel_r]) |=> refused_r && !sampling)
    else $error("shared pin channel was not refused");

  a_res_held_on: assert property (@(posedge clk) disable iff (sys_rst)
    (on_r && $past(on_r)) |-> $stable(res_r))
    else $error("resolution changed while converter enabled");

  a_conv_bit_count: assert property (@(posedge clk) disable iff (sys_rst)
    conv_done |-> (ctads_r == $past(nbits)) && (st_r == ST_HOLDOFF))
    else $error("conversion took the wrong number of tads");

  a_sample_time_len: assert property (@(posedge clk) disable iff (sys_rst)
    (sampling ##1 converting) |-> $past(samp_r) == auto_sample_time)
    else $error("sample phase left before auto_sample_time");

  c_conv_12b: cover property (@(posedge clk) disable iff (sys_rst) conv_done && res_r);
  c_conv_10b_sim: cover property (@(posedge clk) disable iff (sys_rst) sampling && sh_active == SH_ALL);
  c_refused: cover property (@(posedge clk) disable iff (sys_rst) refuse);
  c_back_to_back: cover property (@(posedge clk) disable iff (sys_rst) accept && seen_r);
endmodule // adrt_ctrl

// ==== verif/adrt_analog_model.sv ====
`timescale 1ns/100ps
// analog side: track-and-hold of the selected input and the sar comparator
module adrt_analog_model
  import adrt_pkg::*;
(
  input wire logic clk,
  input wire logic sampling,
  input wire logic converting,
  input wire logic full12,
  input wire logic [RES_W-1:0] level,
  input wire logic [RES_W-1:0] sar_trial,
  output logic sar_comp
);
  logic [RES_W-1:0] held = '0; // level captured at the end of sampling
  logic wobble = 1'b0; // changing pattern so a stray sample is never a stable guess
  // follow the input while sampling, hold it while converting
  always @(posedge clk) begin
    if (sampling) begin
      held <= level;
    end
    wobble <= ~wobble;
  end
  // comparator output, only meaningful during a conversion
  always_comb begin
    if (!converting) begin
      sar_comp = wobble;
    end else if (full12) begin
      sar_comp = (held >= sar_trial);
    end else begin
      // 10 bit scale drops the two lowest bits
      sar_comp = ({2'b00, held[RES_W-1:2]} >= sar_trial);
    end
  end
endmodule // adrt_analog_model

// ==== verif/adc_resolution_timing_control_test.sv ====
`timescale 1ns/100ps
// self-checking bench: register port tasks and conversion sequences
module adc_resolution_timing_control_test;
  import adrt_pkg::*;
  logic clk; // 250 MHz
  logic sys_rst;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic rc_tick = 1'b0; // rc event every third clock
  logic sar_comp;
  logic [SH_W-1:0] sh_active;
  logic [CH_W-1:0] chan_sel;
  logic sampling;
  logic converting;
  logic [RES_W-1:0] sar_trial;
  logic conv_done;
  logic res12_m; // scale the analog model compares on
  logic [RES_W-1:0] lvl; // level of the input now selected
  logic [1:0] tcnt = 2'h0; // rc divider phase
  int cyc = 0;
  int mismatches = 0;
  int check_count = 0;
  logic [DATA_W-1:0] d;

  // analog level of each input, distinct per channel
  function automatic logic [RES_W-1:0] level(input logic [CH_W-1:0] ch);
    return 12'h3A5 + {8'h00, ch} * 12'h0B1;
  endfunction
  assign lvl = level(chan_sel);

  // last input absent on this variant
  adrt_ctrl #(.CH_PRESENT(16'h7FFF)) uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rc_tick(rc_tick),
    .sar_comp(sar_comp), .sh_active(sh_active), .chan_sel(chan_sel), .sampling(sampling),
    .converting(converting), .sar_trial(sar_trial), .conv_done(conv_done));
  adrt_analog_model analog (.clk(clk), .sampling(sampling), .converting(converting), .full12(res12_m),
    .level(lvl), .sar_trial(sar_trial), .sar_comp(sar_comp));

  // clock and cycle count
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tcnt <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
    rc_tick <= (tcnt == 2'h2);
  end

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // 1 when v lies in lo..hi
  function automatic logic [DATA_W-1:0] inr(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
  endfunction

  // full conversion: setup, timing, result, holdoff
  task automatic conv(input logic [3:0] ch, input logic res, input logic sim, input logic [7:0] div,
    input logic [4:0] auto_sample_time, input logic src);
    logic [DATA_W-1:0] ctl;
    logic [SH_W-1:0] sh;
    logic [CH_W-1:0] cs;
    int samp;
    int cnv;
    int t0;
    int u;
    int sl;
    int nb;
    samp = 0;
    cnv = 0;
    sh = '0;
    cs = '0;
    u = (int'(div) + 1) * (src ? 3 : 1);
    sl = src ? 6 : 0;
    nb = res ? 12 : 10;
    ctl = {1'b1, 4'h0, res, 6'h00, sim, 3'h0};
    wr(REG_CTRL, 16'h0000);
    wr(REG_CTRL, ctl & 16'h7FFF);
    wr(REG_TIMING, {src, 2'b00, auto_sample_time, div});
    wr(REG_CHSEL, {12'h000, ch});
    res12_m = res;
    wr(REG_CTRL, ctl | 16'h0001);
    t0 = cyc;
    for (int k = 0; k < 3000; k++) begin
      #1;
      if (sampling === 1'b1) begin
        samp++;
        sh = sh_active;
        cs = chan_sel;
      end
      if (converting === 1'b1) cnv++;
      if (conv_done === 1'b1) break;
      @(posedge clk);
    end
    chk({15'h0, conv_done}, 16'h0001, "done pulse");
    chk(inr(cnv, nb * u - sl, nb * u + sl), 16'h0001, "convert length");
    chk(inr(samp, int'(auto_sample_time) * u, int'(auto_sample_time) * u + u + sl), 16'h0001, "sample length");
    chk({12'h000, cs}, {12'h000, ch}, "channel");
    chk({12'h000, sh}, {12'h000, (res || !sim) ? SH_ONE : SH_ALL}, "sample-and-hold set");
    rd(REG_RESULT, d);
    chk(d, res ? {4'h0, level(ch)} : {4'h0, level(ch) >> 2}, "result");
    rd(REG_STATUS, d);
    chk(d & 16'h0003, 16'h0003, "busy and done");
    wr(REG_CTRL, ctl | 16'h0001);
    #1;
    chk({15'h0, sampling}, 16'h0000, "restart inside holdoff");
    for (int k = 0; k < 400; k++) begin
      rd(REG_STATUS, d);
      if (d[STAT_BUSY_BIT] === 1'b0) break;
    end
    chk(d & 16'h0001, 16'h0000, "idle again");
    chk(inr(cyc - t0, res ? MIN_CYC_12B : MIN_CYC_10B, 100000), 16'h0001, "throughput");
    wr(REG_STATUS, 16'h0006);
    rd(REG_STATUS, d);
    chk(d, 16'h0000, "status cleared");
    // once the holdoff is over a start in the same enabled run is taken at once
    wr(REG_CTRL, ctl | 16'h0001);
    #1;
    chk({15'h0, sampling}, 16'h0001, "restart after holdoff");
    wr(REG_CTRL, 16'h0000);
  endtask

  // start on an unavailable input must be refused
  task automatic refuse(input logic [3:0] ch, input logic [15:0] pins);
    wr(REG_PINSHR, pins);
    wr(REG_CHSEL, {12'h000, ch});
    wr(REG_CTRL, 16'h8001);
    #1;
    chk({15'h0, sampling}, 16'h0000, "refused start sampled");
    rd(REG_STATUS, d);
    chk(d & 16'h0004, 16'h0004, "refused flag");
    wr(REG_STATUS, 16'h0006);
    wr(REG_PINSHR, 16'h0000);
    wr(REG_CTRL, 16'h0000);
  endtask

  // watchdog against a hang
  initial begin
    #100000;
    mismatches++;
    $display("FAIL %0t watchdog expired", $time);
    close_out();
  end

  // main sequence
  initial begin
    sys_rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    res12_m = 1'b0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(REG_TIMING, d);
    chk(d, TIMING_RST, "timing reset value");
    rd(4'hE, d);
    chk(d, 16'h0000, "unmapped read");
    wr(REG_TIMING, 16'hFFFF);
    rd(REG_TIMING, d);
    chk(d, 16'h9FFF, "timing reserved bits");
    wr(REG_CTRL, 16'h0400);
    wr(REG_CTRL, 16'h8400);
    rd(REG_CTRL, d);
    chk(d, 16'h8400, "resolution set while off");
    wr(REG_CTRL, 16'h8000);
    rd(REG_CTRL, d);
    chk(d, 16'h8400, "resolution held while on");
    conv(4'h3, 1'b0, 1'b1, 8'h00, 5'h01, 1'b0);
    conv(4'h9, 1'b1, 1'b1, 8'h02, 5'h03, 1'b0);
    conv(4'hE, 1'b1, 1'b0, 8'h00, 5'h00, 1'b1);
    conv(4'h0, 1'b0, 1'b0, 8'h01, 5'h1F, 1'b0);
    refuse(4'h5, 16'h0020);
    refuse(4'hF, 16'h0000);
    // abort in mid-conversion leaves no result, on an input that exists
    wr(REG_TIMING, 16'h0004);
    wr(REG_CHSEL, 16'h0002);
    wr(REG_CTRL, 16'h8001);
    repeat (15) @(posedge clk);
    #1;
    chk({15'h0, converting}, 16'h0001, "converting before abort");
    wr(REG_CTRL, 16'h0000);
    @(posedge clk);
    #1;
    chk({15'h0, converting}, 16'h0000, "abort stops conversion");
    for (int k = 0; k < 60; k++) begin
      @(posedge clk);
      #1;
      if (conv_done !== 1'b0) chk({15'h0, conv_done}, 16'h0000, "done after abort");
    end
    close_out();
  end
endmodule // adc_resolution_timing_control_test
